// >>> rtl/ucd_counter.sv
// Eight-digit counter core: measurement control, display latch, digit scan.
// Assumes inputs synchronous to clock except hold_i and clear_i,
// and a classic Wishbone master on the register port.
//
// Added by the designer: the register addresses and the Wishbone register port.
module ucd_counter
  import ucd_pkg::*;
#(
  parameter int unsigned DIGIT_CYC     = DIGIT_US * CLK_MHZ,
  parameter int unsigned WIN_BASE_CYC  = RANGE_BASE_US * CLK_MHZ,
  parameter logic        STROBE_ACT_HI = 1'b1,
  parameter int unsigned FIFO_DEPTH    = FIFO_DEPTH_DEF
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              hold_i,
  input  wire logic              clear_i,
  input  wire logic              count_i,
  input  wire logic              ext_range_i,
  input  wire logic              ext_dp_i,
  output logic      [3:0]        bcd_q,
  output logic      [DIGITS-1:0] strobe_q,
  output logic                   blank_q,
  output logic                   dp_q,
  output logic                   meas_q,
  output logic                   store_q,
  output logic                   clr_phase_q
);
  localparam int unsigned SLOT_CYC = GAP_CYC + DIGIT_CYC;
  localparam logic [DIGITS-1:0] STROBE_IDLE = {DIGITS{~STROBE_ACT_HI}};

  ucd_stream_if #(.W(BCD_W + 1)) fill_s ();
  ucd_stream_if #(.W(BCD_W + 1)) drain_s ();

  logic [CTRL_W-1:0]       ctrl_q;
  logic                    hold_meta_q;
  logic                    hold_s_q;
  logic                    clr_meta_q;
  logic                    clr_s_q;
  logic                    cnt_prev_q;
  logic                    ext_prev_q;
  ucd_state_t              state_q;
  ucd_state_t              state_d;
  logic [31:0]             win_q;
  logic [31:0]             win_lim;
  logic [BCD_W-1:0]        cnt_q;
  logic                    ovf_q;
  logic [BCD_W:0]          disp_q;
  logic [31:0]             slot_q;
  logic [31:0]             slot_d;
  logic [IDX_W-1:0]        idx_q;
  logic [IDX_W-1:0]        idx_d;
  logic [IDX_W-1:0]        dp_idx;
  logic                    extdp_seen_q;
  logic                    blank_d;
  logic                    upper_zero;
  logic                    unit;
  logic                    freeze;
  logic                    cnt_edge;
  logic                    win_end;
  logic                    wb_hit;
  logic [CTRL_RANGE_W-1:0] range;
  logic [BCD_W:0]          inc_v;

  assign unit     = ctrl_q[CTRL_UNIT_BIT];
  assign range    = ctrl_q[CTRL_RANGE_LSB +: CTRL_RANGE_W];
  assign freeze   = hold_s_q && !unit;
  assign cnt_edge = cnt_prev_q && !count_i;
  assign wb_hit   = wb_cyc_i && wb_stb_i && !wb_ack_o;

  function automatic logic [DIGITS-1:0] strobe_on(input logic [IDX_W-1:0] i);
    strobe_on = (DIGITS'(1) << i) ^ STROBE_IDLE;
  endfunction : strobe_on

  // ----------------------------------------------------------------
  // Input synchronisers and edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_meta_q <= 1'b0;
      hold_s_q    <= 1'b0;
      clr_meta_q  <= 1'b0;
      clr_s_q     <= 1'b0;
    end else begin
      hold_meta_q <= hold_i;
      hold_s_q    <= hold_meta_q;
      clr_meta_q  <= clear_i;
      clr_s_q     <= clr_meta_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      cnt_prev_q <= count_i;
      ext_prev_q <= ext_range_i;
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (wb_hit && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
      ctrl_q <= wb_dat_i[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= '0;
    end else if (wb_hit && !wb_we_i) begin
      case (wb_adr_i)
        ADR_CTRL: wb_dat_o <= 32'(ctrl_q);
        ADR_STAT: begin
          wb_dat_o                <= '0;
          wb_dat_o[STAT_MEAS_BIT] <= meas_q;
          wb_dat_o[STAT_OVF_BIT]  <= disp_q[BCD_W];
          wb_dat_o[STAT_FULL_BIT] <= !fill_s.ready;
          wb_dat_o[STAT_HOLD_BIT] <= hold_s_q;
          wb_dat_o[STAT_CLR_BIT]  <= clr_s_q;
        end
        ADR_LIVE: wb_dat_o <= cnt_q;
        ADR_DISP: wb_dat_o <= disp_q[BCD_W-1:0];
        default:  wb_dat_o <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Measurement window
  // ----------------------------------------------------------------
  always_comb begin
    case (range)
      3'h0:    win_lim = 32'(WIN_BASE_CYC);
      3'h1:    win_lim = 32'(WIN_BASE_CYC * 10);
      3'h2:    win_lim = 32'(WIN_BASE_CYC * 100);
      3'h3:    win_lim = 32'(WIN_BASE_CYC * 1000);
      default: win_lim = 32'(WIN_BASE_CYC);
    endcase
  end

  // External range replaces the window count only when selected
  assign win_end = (range == RANGE_EXT) ? (ext_prev_q && !ext_range_i)
                                        : (win_q == win_lim - 32'h1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= '0;
    end else if (state_q != ST_MEAS) begin
      win_q <= '0;
    end else begin
      win_q <= win_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_WAIT: begin
        if (!clr_s_q && !freeze) begin
          state_d = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (clr_s_q || freeze) begin
          state_d = ST_WAIT;
        end else if (win_end) begin
          state_d = ST_STORE;
        end
      end
      ST_STORE: begin
        if (clr_s_q) begin
          state_d = ST_WAIT;
        end else if ((unit && hold_s_q) || fill_s.ready) begin
          state_d = ST_CLR;
        end
      end
      ST_CLR: state_d = (clr_s_q || freeze) ? ST_WAIT : ST_MEAS;
      default: state_d = ST_WAIT;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_WAIT;
      meas_q      <= 1'b0;
      store_q     <= 1'b0;
      clr_phase_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      meas_q      <= (state_d == ST_MEAS);
      store_q     <= (state_d == ST_STORE);
      clr_phase_q <= (state_d == ST_CLR);
    end
  end

  // ----------------------------------------------------------------
  // Main counter, BCD with overflow
  // ----------------------------------------------------------------
  always_comb begin
    logic carry;
    carry = 1'b1;
    inc_v = '0;
    for (int i = 0; i < DIGITS; i++) begin
      inc_v[4*i +: 4] = cnt_q[4*i +: 4];
      if (carry) begin
        if (cnt_q[4*i +: 4] == 4'h9) begin
          inc_v[4*i +: 4] = 4'h0;
        end else begin
          inc_v[4*i +: 4] = cnt_q[4*i +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
    inc_v[BCD_W] = carry;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else if (clr_s_q) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else if ((freeze && state_q != ST_STORE) || (state_q == ST_CLR && !unit)) begin
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else if (cnt_edge && (unit || state_q == ST_MEAS)) begin
      cnt_q <= inc_v[BCD_W-1:0];
      ovf_q <= ovf_q || inc_v[BCD_W];
    end
  end

  // ----------------------------------------------------------------
  // Result queue and display latch
  // ----------------------------------------------------------------
  assign fill_s.valid  = (state_q == ST_STORE) && !clr_s_q && !(unit && hold_s_q);
  assign fill_s.data   = {ovf_q, cnt_q};
  assign drain_s.ready = (idx_q == '0) && (slot_q == 32'(SLOT_CYC - 2)) && !clr_s_q
                         && !(unit && hold_s_q);

  ucd_fifo #(
    .W     (BCD_W + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock (clock),
    .rst_n (rst_n),
    .flush (clr_s_q),
    .in_s  (fill_s),
    .out_s (drain_s)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      disp_q <= '0;
    end else if (clr_s_q) begin
      disp_q <= '0;
    end else if (drain_s.valid && drain_s.ready) begin
      disp_q <= drain_s.data;
    end
  end

  // ----------------------------------------------------------------
  // Digit scan
  // ----------------------------------------------------------------
  always_comb begin
    slot_d = (slot_q == 32'(SLOT_CYC - 1)) ? 32'h0 : slot_q + 32'h1;
    idx_d  = idx_q;
    if (slot_q == 32'(SLOT_CYC - 1)) begin
      idx_d = (idx_q == '0) ? IDX_W'(DIGITS - 1) : idx_q - 1'b1;
    end
  end

  // Point sits r+1 digits up so the unit reads kHz
  always_comb begin
    dp_idx = '0;
    if (!unit && !ctrl_q[CTRL_EXTDP_BIT] && range < RANGE_EXT) begin
      dp_idx = IDX_W'(range) + 1'b1;
    end
  end

  always_comb begin
    upper_zero = 1'b1;
    for (int j = 0; j < DIGITS; j++) begin
      if (j > int'(idx_d) && disp_q[4*j +: 4] != 4'h0) begin
        upper_zero = 1'b0;
      end
    end
    blank_d = (disp_q[4*idx_d +: 4] == 4'h0) && upper_zero
              && (idx_d > dp_idx)
              && !disp_q[BCD_W]
              && !(extdp_seen_q && idx_q != '0);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_q  <= '0;
      idx_q   <= IDX_W'(DIGITS - 1);
      bcd_q   <= '0;
      blank_q <= 1'b0;
    end else begin
      slot_q <= slot_d;
      idx_q  <= idx_d;
      if (slot_q == 32'(SLOT_CYC - 1)) begin
        bcd_q   <= disp_q[4*idx_d +: 4];
        blank_q <= blank_d;
      end
    end
  end

  // Strobe rises one gap after the BCD change
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strobe_q <= STROBE_IDLE;
    end else if (slot_d >= 32'(GAP_CYC)) begin
      strobe_q <= strobe_on(idx_d);
    end else begin
      strobe_q <= STROBE_IDLE;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      extdp_seen_q <= 1'b0;
      dp_q         <= 1'b0;
    end else begin
      if (slot_q == 32'(SLOT_CYC - 1) && idx_q == '0) begin
        extdp_seen_q <= 1'b0;
      end else if (ctrl_q[CTRL_EXTDP_BIT] && slot_q >= 32'(GAP_CYC)
                   && ext_dp_i == STROBE_ACT_HI) begin
        extdp_seen_q <= 1'b1;
      end
      if (slot_d < 32'(GAP_CYC)) begin
        dp_q <= 1'b0;
      end else if (ctrl_q[CTRL_EXTDP_BIT]) begin
        dp_q <= (ext_dp_i == STROBE_ACT_HI);
      end else begin
        dp_q <= (dp_idx != '0) && (idx_d == dp_idx);
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_freeze_abort;
    @(posedge clock) disable iff (!rst_n)
    hold_s_q && !unit && state_q != ST_STORE |=> cnt_q == '0 && !meas_q;
  endproperty
  a_freeze_abort: assert property (p_freeze_abort) else $error("freeze did not abort");

  property p_freeze_no_store;
    @(posedge clock) disable iff (!rst_n)
    hold_s_q && !unit && state_q == ST_MEAS |=> !store_q;
  endproperty
  a_freeze_no_store: assert property (p_freeze_no_store) else $error("store under freeze");

  property p_unit_runs;
    @(posedge clock) disable iff (!rst_n)
    unit && !clr_s_q && cnt_edge |=> cnt_q != $past(cnt_q);
  endproperty
  a_unit_runs: assert property (p_unit_runs) else $error("unit count stalled");

  property p_clear;
    @(posedge clock) disable iff (!rst_n)
    clr_s_q |=> cnt_q == '0 && disp_q == '0 && !meas_q && !store_q;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left state");

  property p_ext_end;
    @(posedge clock) disable iff (!rst_n)
    state_q == ST_MEAS && range == RANGE_EXT && ext_prev_q && !ext_range_i
      && !clr_s_q && !freeze |=> store_q;
  endproperty
  a_ext_end: assert property (p_ext_end) else $error("external range ignored");

  property p_clr_after_store;
    @(posedge clock) disable iff (!rst_n)
    $rose(clr_phase_q) |-> $past(store_q) && !meas_q;
  endproperty
  a_clr_after_store: assert property (p_clr_after_store) else $error("phase order");

  property p_scan_down;
    @(posedge clock) disable iff (!rst_n)
    slot_q == 32'(SLOT_CYC - 1) && idx_q != '0 |=> idx_q == $past(idx_q) - 1'b1;
  endproperty
  a_scan_down: assert property (p_scan_down) else $error("scan order");

  property p_scan_wrap;
    @(posedge clock) disable iff (!rst_n)
    slot_q == 32'(SLOT_CYC - 1) && idx_q == '0 |=> idx_q == IDX_W'(DIGITS - 1);
  endproperty
  a_scan_wrap: assert property (p_scan_wrap) else $error("scan wrap");

  property p_strobe_lag;
    @(posedge clock) disable iff (!rst_n)
    slot_q == 32'(GAP_CYC) |-> strobe_q == strobe_on(idx_q)
      && $past(strobe_q) == STROBE_IDLE;
  endproperty
  a_strobe_lag: assert property (p_strobe_lag) else $error("strobe lag");

  property p_bcd_true;
    @(posedge clock) disable iff (!rst_n)
    $changed(idx_q) && !$past(clr_s_q) |-> bcd_q == disp_q[4*idx_q +: 4];
  endproperty
  a_bcd_true: assert property (p_bcd_true) else $error("bcd mismatch");

  property p_ovf_no_blank;
    @(posedge clock) disable iff (!rst_n)
    $changed(idx_q) && !$past(clr_s_q) && disp_q[BCD_W] |-> !blank_q;
  endproperty
  a_ovf_no_blank: assert property (p_ovf_no_blank) else $error("blank on overflow");

  property p_lsd_shown;
    @(posedge clock) disable iff (!rst_n)
    $changed(idx_q) && idx_q == '0 |-> !blank_q;
  endproperty
  a_lsd_shown: assert property (p_lsd_shown) else $error("lsd blanked");

endmodule : ucd_counter

// >>> rtl/ucd_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush input.
// Assumes DEPTH is a power of two.
module ucd_fifo #(
  parameter int unsigned W     = 33,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic  clock,
  input  wire logic  rst_n,
  input  wire logic  flush,
  ucd_stream_if.rx   in_s,
  ucd_stream_if.tx   out_s
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty       = (wr_q == rd_q);
  assign in_s.ready  = !full;
  assign out_s.valid = !empty;
  assign out_s.data  = mem[rd_q[AW-1:0]];
  assign push        = in_s.valid && !full;
  assign pop         = out_s.ready && !empty;

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (push && !flush) begin
      mem[wr_q[AW-1:0]] <= in_s.data;
    end
  end

endmodule : ucd_fifo

// >>> rtl/ucd_pkg.sv
// Constants, field layout and types of the universal counter core.
// Assumes a single 250 MHz clock and classic Wishbone register access.
package ucd_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned DIGITS         = 8;
  localparam int unsigned BCD_W          = 4 * DIGITS;
  localparam int unsigned IDX_W          = $clog2(DIGITS);
  localparam int unsigned FIFO_DEPTH_DEF = 16;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_LIVE = 8'h08;
  localparam logic [7:0] ADR_DISP = 8'h0C;

  localparam int unsigned CTRL_W         = 5;
  localparam int unsigned CTRL_RANGE_LSB = 0;
  localparam int unsigned CTRL_RANGE_W   = 3;
  localparam int unsigned CTRL_UNIT_BIT  = 3;
  localparam int unsigned CTRL_EXTDP_BIT = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  localparam logic [CTRL_RANGE_W-1:0] RANGE_EXT = 3'h4;

  localparam int unsigned STAT_MEAS_BIT = 0;
  localparam int unsigned STAT_OVF_BIT  = 1;
  localparam int unsigned STAT_FULL_BIT = 2;
  localparam int unsigned STAT_HOLD_BIT = 3;
  localparam int unsigned STAT_CLR_BIT  = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned DIGIT_US      = 244;
  localparam int unsigned GAP_US        = 6;
  localparam int unsigned RANGE_BASE_US = 10000;
  localparam int unsigned GAP_CYC       = GAP_US * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_WAIT,
    ST_MEAS,
    ST_STORE,
    ST_CLR
  } ucd_state_t;

endpackage : ucd_pkg

// >>> rtl/ucd_stream_if.sv
// Valid/ready word stream between the counter core and its FIFO.
// Assumes both ends share one clock.
interface ucd_stream_if #(
  parameter int unsigned W = 33
) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface : ucd_stream_if

// >>> tb/counter_hold_reset_digit_scan_bench.sv
// Self-checking bench of the counter core: bus accesses, freeze, clear, scan.
// Assumes short DIGIT_CYC and WIN_BASE_CYC and the display model beside the core.
module counter_hold_reset_digit_scan_bench
  import ucd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int FRAME = 8 * (GAP_CYC + 20);

  logic        clock;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        hold;
  logic        clr;
  logic        cnt;
  logic        xr;
  logic [3:0]  bcd;
  logic [7:0]  strobe;
  logic        blank;
  logic        dp;
  logic [7:0]  dps;
  logic        meas;
  logic        store;
  logic        clrph;
  logic [31:0] lat;
  logic [7:0]  blk;
  logic [15:0] errs;
  logic [31:0] d;
  int          mismatches;
  int          num_checks;
  int          n;

  ucd_counter #(.DIGIT_CYC(20), .WIN_BASE_CYC(50)) dut (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .hold_i(hold), .clear_i(clr), .count_i(cnt), .ext_range_i(xr),
    .ext_dp_i(strobe[2]),
    .bcd_q(bcd), .strobe_q(strobe), .blank_q(blank), .dp_q(dp), .meas_q(meas),
    .store_q(store), .clr_phase_q(clrph));

  ucd_display_model model (.clock(clock), .rst_n(rst_n), .bcd(bcd), .strobe(strobe),
    .blank(blank), .dp(dp), .lat_o(lat), .blk_o(blk), .dp_o(dps), .err_o(errs));

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= wd;
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(d, exp);
  endtask : rd_chk

  task automatic tick(input int c);
    repeat (c) @(posedge clock);
  endtask : tick

  task automatic pulses(input int c);
    repeat (c) begin
      @(posedge clock);
      cnt <= 1'b1;
      @(posedge clock);
      cnt <= 1'b0;
    end
  endtask : pulses

  // --------------------------------------------------------------
  // Clock, reset, watchdog
  // --------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    stop_test();
  end

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, hold, clr, cnt} = 6'h00;
    adr   = 8'h00;
    wdat  = 32'h0;
    xr    = 1'b1;
    tick(10);
    rst_n <= 1'b1;
    rd_chk(ADR_CTRL, 32'(CTRL_RST));
    wb(1'b1, 8'h10, 32'h0000_00FF);
    rd_chk(8'h10, 32'h0);
    // External range window, one result through to the display
    hold <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'(RANGE_EXT));
    hold <= 1'b0;
    tick(4);
    pulses(123);
    rd_chk(ADR_LIVE, 32'h0000_0123);
    xr <= 1'b0;
    n = 0;
    while (store !== 1'b1 && n < 10) begin
      @(posedge clock);
      n++;
    end
    chk(32'(n < 10), 32'h1);
    chk({31'h0, meas}, 32'h0);
    n = 0;
    while (clrph !== 1'b1 && n < 10) begin
      @(posedge clock);
      n++;
    end
    chk(32'(n < 10), 32'h1);
    xr <= 1'b1;
    n = 0;
    do begin
      wb(1'b0, ADR_DISP, 32'h0);
      n++;
    end while (d !== 32'h0000_0123 && n < 9000);
    chk(d, 32'h0000_0123);
    tick(2 * FRAME);
    chk(lat, 32'h0000_0123);
    chk({24'h0, blk}, 32'h0000_00F8);
    chk({16'h0, errs}, 32'h0);
    // Freeze outside unit mode
    pulses(7);
    hold <= 1'b1;
    tick(4);
    pulses(2);
    rd_chk(ADR_LIVE, 32'h0);
    rd_chk(ADR_DISP, 32'h0000_0123);
    hold <= 1'b0;
    tick(4);
    pulses(2);
    rd_chk(ADR_LIVE, 32'h0000_0002);
    // Clear
    clr <= 1'b1;
    tick(4);
    rd_chk(ADR_LIVE, 32'h0);
    rd_chk(ADR_DISP, 32'h0);
    chk({31'h0, meas}, 32'h0);
    // Unit counting under hold
    wb(1'b1, ADR_CTRL, 32'h1 << CTRL_UNIT_BIT);
    clr <= 1'b0;
    tick(4);
    pulses(5);
    rd_chk(ADR_LIVE, 32'h0000_0005);
    hold <= 1'b1;
    tick(4);
    pulses(3);
    rd_chk(ADR_LIVE, 32'h0000_0008);
    hold <= 1'b0;
    // Decimal point placement over a cleared display
    clr <= 1'b1;
    wb(1'b1, ADR_CTRL, 32'h1 << CTRL_EXTDP_BIT);
    tick(2 * FRAME);
    chk(lat, 32'h0);
    chk({24'h0, dps}, 32'h0000_0004);
    chk({24'h0, blk}, 32'h0000_00FC);
    wb(1'b1, ADR_CTRL, 32'h1);
    tick(2 * FRAME);
    chk({24'h0, dps}, 32'h0000_0004);
    chk({24'h0, blk}, 32'h0000_00F8);
    chk({16'h0, errs}, 32'h0);
    stop_test();
  end
endmodule : counter_hold_reset_digit_scan_bench

// >>> tb/ucd_display_model.sv
// Model of the external BCD latches and multiplexed display on the digit lines.
// Assumes a one-hot digit strobe of polarity ACT_HI and one shared clock.
module ucd_display_model #(
  parameter logic ACT_HI = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [3:0]  bcd,
  input  wire logic [7:0]  strobe,
  input  wire logic        blank,
  input  wire logic        dp,
  output logic      [31:0] lat_o,
  output logic      [7:0]  blk_o,
  output logic      [7:0]  dp_o,
  output logic      [15:0] err_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0]  act;
  logic [7:0]  act_prev;
  logic [31:0] cur;
  logic [7:0]  cur_blk;
  logic [7:0]  cur_dp;
  logic [15:0] gap;
  logic [2:0]  idx;
  logic [2:0]  prev_idx;
  logic        seen;
  logic        bad_gap;
  logic        bad_ord;

  assign act = ACT_HI ? strobe : ~strobe;
  assign bad_gap = (gap < 16'h01F4) || (gap > 16'h05DC);
  assign bad_ord = seen && (idx != prev_idx - 3'h1);

  always_comb begin
    idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (act[i]) idx = i[2:0];
    end
  end

  // --------------------------------------------------------------
  // Latch on the strobe's leading edge, snapshot after the LSD
  // --------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      act_prev <= 8'h00;
      gap      <= 16'h0000;
      cur      <= 32'h0;
      cur_blk  <= 8'h00;
      cur_dp   <= 8'h00;
      dp_o     <= 8'h00;
      prev_idx <= 3'h0;
      seen     <= 1'b0;
      lat_o    <= 32'h0;
      blk_o    <= 8'h00;
      err_o    <= 16'h0000;
    end else begin
      act_prev <= act;
      gap      <= (act == 8'h00) ? gap + 16'h0001 : 16'h0000;
      if (act != 8'h00 && act_prev == 8'h00) begin
        cur[4*idx +: 4] <= bcd;
        cur_blk[idx]    <= blank;
        cur_dp[idx]     <= dp;
        err_o           <= err_o + {15'h0, bad_gap} + {15'h0, bad_ord};
        prev_idx        <= idx;
        seen            <= 1'b1;
        if (idx == 3'h0) begin
          lat_o <= {cur[31:4], bcd};
          blk_o <= {cur_blk[7:1], blank};
          dp_o  <= {cur_dp[7:1], dp};
        end
      end else if (act != 8'h00 && dp) begin
        cur_dp[idx] <= 1'b1;
      end
    end
  end
endmodule : ucd_display_model
